// ===== hw/afesp_serial_clock_ctrl.sv
// Purpose: Serial port, control registers and clock dividers of the front end
// Assumes: external_master_clock_in well below a quarter of clk_in
// Notes:   Front end is link master and drives the serial bit clock
`timescale 1ns/1ps
`include "afesp_cfg.svh"

// What this block does
// - Port mode select 0 gives control mode with register writes and reads.
// - Data mode without mixed ignores input words, sends only samples.
// - Mixed mode flags each word in bit 15, samples cut to 15 bits.
// - One 16-bit shift register, overwritten with newest sample at each event.
// - Serial clock rate bounds the words that fit between sample events.
// - Master divider code gives divide by 1 to 5, unused codes divide by 1.
// - After reset the master divider divides by one.
// - Serial clock is master clock over 8, 4, 2 or 1; 8 after reset.
// - Sample rate is master clock over 2048 to 256; 2048 after reset.
// - Serial and sample dividers run from the divided master clock.
// - Eight 8-bit read/write registers at addresses 0 to 7, reset to zero.
// - Register updates land on the falling serial clock edge.
// - Words shift at the serial clock, most significant bit first.
// - The front end starts every transfer as link master.
// - Control word: flag, read/write, device address, register address, data.
// - Nonzero device address is decremented and the word passed on.
module afesp_serial_clock_ctrl
  import afesp_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        external_master_clock_in,
  input  wire logic        serial_data_in,
  input  wire logic [15:0] sample_word_in,
  output afesp_link_t      link_out,
  output logic             sample_event_out,
  output logic             device_master_clock_out,
  output logic [63:0]      config_regs_out
);

  // ---------------------------------------------
  // Decoding functions
  // ---------------------------------------------
  // Codes above four fall back to divide by one
  function automatic logic [2:0] mck_limit(input logic [2:0] code);
    case (code)
      3'h1:    mck_limit = `AFESP_MCK_DIV2;
      3'h2:    mck_limit = `AFESP_MCK_DIV3;
      3'h3:    mck_limit = `AFESP_MCK_DIV4;
      3'h4:    mck_limit = `AFESP_MCK_DIV5;
      default: mck_limit = `AFESP_MCK_DIV1;
    endcase
  endfunction

  function automatic logic [2:0] sck_limit(input logic [1:0] code);
    case (code)
      2'h1:    sck_limit = `AFESP_SCK_DIV4;
      2'h2:    sck_limit = `AFESP_SCK_DIV2;
      2'h3:    sck_limit = `AFESP_SCK_DIV1;
      default: sck_limit = `AFESP_SCK_DIV8;
    endcase
  endfunction

  function automatic logic [11:0] smp_limit(input logic [1:0] code);
    case (code)
      2'h1:    smp_limit = `AFESP_SMP_DIV1024;
      2'h2:    smp_limit = `AFESP_SMP_DIV512;
      2'h3:    smp_limit = `AFESP_SMP_DIV256;
      default: smp_limit = `AFESP_SMP_DIV2048;
    endcase
  endfunction

  // ---------------------------------------------
  // Declarations
  // ---------------------------------------------
  logic [7:0]       cfg_q [8];
  logic [2:0]       mck_sync_q;
  logic [1:0]       sdi_sync_q;
  logic [2:0]       mck_cnt_q;
  logic [2:0]       sck_cnt_q;
  logic [11:0]      smp_cnt_q;
  logic             device_master_clock_q;
  logic             sclk_q;
  logic             fsync_q;
  logic             sdo_q;
  logic             smp_evt_q;
  logic [15:0]      sr_q;
  logic [15:0]      sr_d;
  logic [3:0]       bit_q;
  afesp_state_t     state_q;
  afesp_state_t     state_d;

  logic [7:0]       port_mode;
  logic [7:0]       clock_rate;
  logic             mode_data;
  logic             mode_mixed;
  logic             mixed_active;
  logic             mck_edge;
  logic             dm_half;
  logic             sck_half;
  logic             sck_rise;
  logic             sck_fall;
  logic             smp_evt;
  logic             shifting;
  logic             word_done;
  logic [15:0]      rx_raw;
  logic             sdi_bit;
  logic             shift_step;
  logic             load_word;
  afesp_ctrl_word_t rx;
  logic             accept;
  logic             for_me;
  logic             reg_wr;
  logic             reg_rd;
  logic             pass_on;
  logic             soft_rst;
  logic [15:0]      smp_word;
  logic [15:0]      reply_word;
  logic [15:0]      fwd_word;

  // ---------------------------------------------
  // Mode decode
  // ---------------------------------------------
  assign port_mode    = cfg_q[`AFESP_REG_PORT_MODE];
  assign clock_rate   = cfg_q[`AFESP_REG_CLOCK_RATE];
  assign mode_data    = port_mode[`AFESP_PM_DATA_PROGRAM];
  assign mode_mixed   = port_mode[`AFESP_PM_MIXED_MODE];
  assign mixed_active = mode_data & mode_mixed;

  // ---------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------
  // Stage 0 feeds only stage 1; edges are taken from stages 1 and 2
  // The input bit lags the pin by two cycles, so fast serial rates need margin
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mck_sync_q <= 3'h0;
      sdi_sync_q <= 2'h0;
    end else begin
      mck_sync_q <= {mck_sync_q[1:0], external_master_clock_in};
      sdi_sync_q <= {sdi_sync_q[0], serial_data_in};
    end
  end

  assign mck_edge = mck_sync_q[1] ^ mck_sync_q[2];
  assign sdi_bit  = sdi_sync_q[1];

  // ---------------------------------------------
  // Clock dividers
  // ---------------------------------------------
  // Counting both pin edges gives half periods, so odd ratios keep their rate
  // The divided clock is a registered level, never used to clock logic
  assign dm_half  = mck_edge & (mck_cnt_q >= mck_limit(clock_rate[`AFESP_CR_MASTER_LSB +: 3]));
  assign sck_half = dm_half & (sck_cnt_q >= sck_limit(clock_rate[`AFESP_CR_SERIAL_LSB +: 2]));
  assign smp_evt  = dm_half & (smp_cnt_q >= smp_limit(clock_rate[`AFESP_CR_DECIM_LSB +: 2]));
  assign sck_rise = sck_half & ~sclk_q;
  assign sck_fall = sck_half & sclk_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mck_cnt_q <= 3'h0;
      device_master_clock_q   <= 1'b0;
    end else if (mck_edge) begin
      mck_cnt_q <= dm_half ? 3'h0 : mck_cnt_q + 3'h1;
      device_master_clock_q   <= device_master_clock_q ^ dm_half;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sck_cnt_q <= 3'h0;
      smp_cnt_q <= 12'h000;
    end else if (dm_half) begin
      sck_cnt_q <= sck_half ? 3'h0 : sck_cnt_q + 3'h1;
      smp_cnt_q <= smp_evt ? 12'h000 : smp_cnt_q + 12'h001;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sclk_q    <= 1'b0;
      smp_evt_q <= 1'b0;
    end else begin
      sclk_q    <= sclk_q ^ sck_half;
      smp_evt_q <= smp_evt;
    end
  end

  // ---------------------------------------------
  // Received word decode
  // ---------------------------------------------
  assign shifting  = (state_q == AFESP_SHIFT);
  assign word_done = shifting & sck_fall & (bit_q == `AFESP_LAST_BIT);
  assign rx_raw    = {sr_q[14:0], sdi_bit};
  assign rx        = afesp_ctrl_word_t'(rx_raw);

  // Data mode alone drops every input word; flag low is never a control word
  assign accept   = rx.ctrl & (~mode_data | mode_mixed);
  assign for_me   = word_done & accept & (rx.dev == 3'h0);
  assign pass_on  = word_done & accept & (rx.dev != 3'h0);
  assign reg_wr   = for_me & ~rx.rd;
  assign reg_rd   = for_me & rx.rd;
  assign soft_rst = reg_wr & (rx.reg_addr == `AFESP_REG_PORT_MODE) & rx.data[`AFESP_PM_SOFT_RESET];

  assign reply_word = {rx_raw[15:8], cfg_q[rx.reg_addr]};
  assign fwd_word   = {rx_raw[15:14], rx.dev - 3'h1, rx_raw[10:0]};
  assign smp_word   = mixed_active ? {1'b0, sample_word_in[15:1]} : sample_word_in;

  // ---------------------------------------------
  // Frame control
  // ---------------------------------------------
  // A sample event wins over a reply, so a late reply is dropped, never merged
  assign shift_step = shifting & sck_fall;
  assign load_word  = smp_evt | reg_rd | pass_on;

  // ---------------------------------------------
  // Shift register control
  // ---------------------------------------------
  // A reply or passed word goes out in the frame right after it arrives
  always_comb begin
    sr_d    = sr_q;
    state_d = state_q;
    if (smp_evt) begin
      sr_d    = smp_word;
      state_d = AFESP_SHIFT;
    end else if (reg_rd) begin
      sr_d    = reply_word;
      state_d = AFESP_SHIFT;
    end else if (pass_on) begin
      sr_d    = fwd_word;
      state_d = AFESP_SHIFT;
    end else if (word_done) begin
      sr_d    = rx_raw;
      state_d = AFESP_IDLE;
    end else if (shift_step) begin
      sr_d    = rx_raw;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sr_q    <= 16'h0000;
      state_q <= AFESP_IDLE;
    end else begin
      sr_q    <= sr_d;
      state_q <= state_d;
    end
  end

  // Bit counter restarts whenever a new word is loaded
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bit_q <= 4'h0;
    end else if (load_word || word_done) begin
      bit_q <= 4'h0;
    end else if (shift_step) begin
      bit_q <= bit_q + 4'h1;
    end
  end

  // ---------------------------------------------
  // Link outputs
  // ---------------------------------------------
  // Data and frame sync change on the rising edge, input is taken on the fall
  // Outputs hold a full bit period, so the slave can sample mid-bit
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sdo_q <= 1'b0;
    end else if (sck_rise) begin
      sdo_q <= shifting & sr_q[15];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fsync_q <= 1'b0;
    end else if (sck_rise) begin
      fsync_q <= shifting & (bit_q == 4'h0);
    end
  end

  assign link_out.sclk  = sclk_q;
  assign link_out.fsync = fsync_q;
  assign link_out.sdo   = sdo_q;

  assign sample_event_out        = smp_evt_q;
  assign device_master_clock_out = device_master_clock_q;

  // ---------------------------------------------
  // Control registers
  // ---------------------------------------------
  // Writes complete on the falling serial clock edge that ends the word
  // Soft reset clears the whole map, including the word that asked for it
  for (genvar i = 0; i < 8; i++) begin : g_reg
    always_ff @(posedge clk_in) begin
      if (rst_in || soft_rst) begin
        cfg_q[i] <= `AFESP_REG_RESET;
      end else if (reg_wr && (rx.reg_addr == 3'(i))) begin
        cfg_q[i] <= rx.data;
      end
    end
    assign config_regs_out[i*8 +: 8] = cfg_q[i];
  end

endmodule

// ===== include/afesp_cfg.svh
// Purpose: Offsets, field positions, reset values and divider counts
// Assumes: Included by the core module only, not by the package
// Notes:   Counts are in half periods of the clock they divide
`ifndef AFESP_CFG_SVH
`define AFESP_CFG_SVH

// ---------------------------------------------
// Register offsets
// ---------------------------------------------
`define AFESP_REG_PORT_MODE    3'h0
`define AFESP_REG_CLOCK_RATE   3'h1
`define AFESP_REG_REF_POWER    3'h2
`define AFESP_REG_PAIR_ONE     3'h3
`define AFESP_REG_PAIR_TWO     3'h4
`define AFESP_REG_PAIR_THREE   3'h5
`define AFESP_REG_AUX_G        3'h6
`define AFESP_REG_AUX_H        3'h7
`define AFESP_REG_RESET        8'h00

// ---------------------------------------------
// Field positions
// ---------------------------------------------
`define AFESP_PM_DATA_PROGRAM  0
`define AFESP_PM_MIXED_MODE    1
`define AFESP_PM_SOFT_RESET    7
`define AFESP_CR_DECIM_LSB     0
`define AFESP_CR_SERIAL_LSB    2
`define AFESP_CR_MASTER_LSB    4

// ---------------------------------------------
// Divider limits (count value minus one)
// ---------------------------------------------
`define AFESP_MCK_DIV1         3'h0
`define AFESP_MCK_DIV2         3'h1
`define AFESP_MCK_DIV3         3'h2
`define AFESP_MCK_DIV4         3'h3
`define AFESP_MCK_DIV5         3'h4
`define AFESP_SCK_DIV8         3'h7
`define AFESP_SCK_DIV4         3'h3
`define AFESP_SCK_DIV2         3'h1
`define AFESP_SCK_DIV1         3'h0
`define AFESP_SMP_DIV2048      12'hfff
`define AFESP_SMP_DIV1024      12'h7ff
`define AFESP_SMP_DIV512       12'h3ff
`define AFESP_SMP_DIV256       12'h1ff
`define AFESP_LAST_BIT         4'hf
`endif

// ===== include/afesp_pkg.sv
// Purpose: Types shared by the serial port and clock control block
// Assumes: Constants live in afesp_cfg.svh
// Notes:   Control word layout is bit 15 down to bit 0
package afesp_pkg;

  // ---------------------------------------------
  // Control word
  // ---------------------------------------------
  typedef struct packed {
    logic       ctrl;
    logic       rd;
    logic [2:0] dev;
    logic [2:0] reg_addr;
    logic [7:0] data;
  } afesp_ctrl_word_t;

  // ---------------------------------------------
  // Link pins driven by the front end
  // ---------------------------------------------
  typedef struct packed {
    logic sclk;
    logic fsync;
    logic sdo;
  } afesp_link_t;

  typedef enum logic {
    AFESP_IDLE,
    AFESP_SHIFT
  } afesp_state_t;

endpackage

// ===== sim/afe_serial_port_clock_control_test.sv
// Purpose: Self-checking bench of the serial port and clock block
// Assumes: External clock half period of 3 cycles
// Notes:   First write speeds the rates up to keep the run short
`timescale 1ns/1ps
module afe_serial_port_clock_control_test;
  import afesp_pkg::*;
  // --------
  // Harness
  // --------
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        emc = 1'b0;
  logic        sd, sev, dmc, done;
  logic [15:0] smp = 16'ha5c3;
  logic [15:0] tx = 16'h0000;
  logic [15:0] rx, r;
  logic [63:0] regs;
  afesp_link_t lnk;
  int          failures = 0;
  int          checks = 0;
  int          cyc = 0;
  always #2 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc % 3 == 2) emc <= ~emc;
    if (cyc == 150000) begin
      failures = failures + 1;
      end_of_test;
    end
  end
  afesp_serial_clock_ctrl u_afesp_serial_clock_ctrl (.clk_in, .rst_in, .external_master_clock_in(emc),
    .serial_data_in(sd), .sample_word_in(smp), .link_out(lnk), .sample_event_out(sev),
    .device_master_clock_out(dmc), .config_regs_out(regs));
  afesp_proc_model u_afesp_proc_model (.clk_in, .link_in(lnk), .tx_word_in(tx), .sd_out(sd),
    .rx_word_out(rx), .rx_done_out(done));
  // --------
  // Tasks
  // --------
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    if (failures == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Ends one cycle after a frame, so the next word is set before the next frame sync
  task automatic wdone;
    do @(posedge clk_in); while (done !== 1'b1);
    r = rx;
    @(posedge clk_in);
  endtask
  task automatic xfer(input logic [15:0] w);
    tx <= w;
    wdone;
  endtask
  // Half period of the master clock (s = 0) or the serial clock (s = 1)
  task automatic hp(input logic s, input int e);
    logic p, v;
    int n;
    p = s ? lnk.sclk : dmc;
    repeat (3) begin
      n = 0;
      do begin
        @(posedge clk_in);
        n++;
        v = s ? lnk.sclk : dmc;
      end while (v === p && n < 999);
      p = v;
    end
    cmp(64'(n), 64'(e));
  endtask
  task automatic sck(input int e);
    do @(posedge clk_in); while (sev !== 1'b1);
    hp(1'b1, e);
    wdone;
  endtask
  // --------
  // Tests
  // --------
  initial begin
    int n;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    cmp(regs, 64'h0);
    hp(1'b0, 3);
    tx <= 16'h810b;
    sck(24);
    cmp(r, smp);
    cmp(regs, 64'h0b00);
    for (int c = 0; c < 8; c++) begin
      xfer({8'h81, 1'b0, c[2:0], 4'hb});
      hp(1'b0, 3 * ((c > 0 && c < 5) ? c + 1 : 1));
    end
    for (int s = 1; s < 4; s++) begin
      xfer({8'h81, 4'h1, s[1:0], 2'h3});
      sck(48 >> s);
    end
    do @(posedge clk_in); while (sev !== 1'b1);
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (sev !== 1'b1 && n < 9999);
    cmp(64'(n), 64'd3072);
    wdone;
    xfer(16'h810b);
    for (int i = 2; i < 8; i++) xfer({5'h10, i[2:0], 8'h11 * i[7:0]});
    cmp(regs, 64'h7766_5544_3322_0b00);
    xfer(16'hc500);
    xfer(16'h0000);
    cmp(r, 16'hc555);
    xfer(16'h9344);
    xfer(16'h0000);
    cmp(r, 16'h8b44);
    xfer(16'h0399);
    cmp(regs, 64'h7766_5544_3322_0b00);
    smp <= 16'h5a3c;
    xfer(16'h8003);
    xfer(16'h8200);
    cmp(r, 16'h2d1e);
    xfer(16'h8002);
    xfer(16'h82ff);
    cmp(r, smp);
    cmp(regs, 64'h7766_5544_33ff_0b02);
    xfer(16'h8001);
    xfer(16'h8211);
    cmp(r, smp);
    cmp(regs, 64'h7766_5544_33ff_0b01);
    end_of_test;
  end
endmodule

// ===== sim/afesp_proc_model.sv
// Purpose: Processor serial port, slave on the link
// Assumes: Serial clock half period of 3 cycles or more
// Notes:   Released data line toggles, never holds its last bit
`timescale 1ns/1ps
module afesp_proc_model
  import afesp_pkg::*;
(
  input  logic        clk_in,
  input  afesp_link_t link_in,
  input  logic [15:0] tx_word_in,
  output logic        sd_out,
  output logic [15:0] rx_word_out,
  output logic        rx_done_out
);
  // --------
  // Slave shifter
  // --------
  logic        sclk_q = 1'b0;
  logic [4:0]  sent_q = 5'h10;
  logic [4:0]  took_q = 5'h10;
  logic [15:0] tx_q;
  logic [15:0] rx_q;
  initial sd_out = 1'b0;
  initial rx_done_out = 1'b0;
  always @(posedge clk_in) begin
    sclk_q <= link_in.sclk;
    rx_done_out <= 1'b0;
    if (link_in.sclk && !sclk_q) begin
      if (link_in.fsync) begin
        {sd_out, tx_q} <= {tx_word_in, 1'b0};
        sent_q <= 5'h01;
        took_q <= 5'h00;
      end else if (sent_q < 5'h10) begin
        {sd_out, tx_q} <= {tx_q, 1'b0};
        sent_q <= sent_q + 5'h01;
      end else sd_out <= ~sd_out;
    end
    if (!link_in.sclk && sclk_q && took_q < 5'h10) begin
      rx_q <= {rx_q[14:0], link_in.sdo};
      rx_word_out <= {rx_q[14:0], link_in.sdo};
      rx_done_out <= (took_q == 5'h0f);
      took_q <= took_q + 5'h01;
    end
  end
endmodule

// ===== sim/afesp_sva.sv
// Purpose: Port checks of the serial port and clock block
// Assumes: Serial clock half period of 3 cycles or more
// Notes:   Bound to the core module
`timescale 1ns/1ps
module afesp_sva
  import afesp_pkg::*;
(
  input logic        clk_in,
  input logic        rst_in,
  input logic        external_master_clock_in,
  input logic        serial_data_in,
  input logic [15:0] sample_word_in,
  input afesp_link_t link_out,
  input logic        sample_event_out,
  input logic        device_master_clock_out,
  input logic [63:0] config_regs_out
);
  // --------
  // Checks
  // --------
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_rst; $fell(rst_in) |-> config_regs_out == 64'h0 && !device_master_clock_out; endproperty
  a_rst: assert property (p_rst) else $error("not clear after reset");
  property p_evt; sample_event_out |=> !sample_event_out [*8]; endproperty
  a_evt: assert property (p_evt) else $error("sample events too close");
  property p_sdo; $changed(link_out.sdo) |-> link_out.sclk && !$past(link_out.sclk, 2); endproperty
  a_sdo: assert property (p_sdo) else $error("data moved off a rising edge");
  property p_fs; $changed(link_out.fsync) |-> link_out.sclk && !$past(link_out.sclk, 2); endproperty
  a_fs: assert property (p_fs) else $error("frame sync moved off a rising edge");
  property p_wr; $changed(config_regs_out) |-> ##[0:1] !link_out.sclk; endproperty
  a_wr: assert property (p_wr) else $error("register moved off a falling edge");
  property p_dat; config_regs_out[1:0] == 2'h1 |=> $stable(config_regs_out); endproperty
  a_dat: assert property (p_dat) else $error("write taken in data mode");
  property p_frm; sample_event_out |-> ##[0:1000] link_out.fsync; endproperty
  a_frm: assert property (p_frm) else $error("no frame after sample event");
  property p_fw; $rose(link_out.fsync) |-> link_out.fsync [*6]; endproperty
  a_fw: assert property (p_fw) else $error("frame sync too short");
endmodule
bind afesp_serial_clock_ctrl afesp_sva u_afesp_sva (.clk_in, .rst_in, .external_master_clock_in,
  .serial_data_in, .sample_word_in, .link_out, .sample_event_out, .device_master_clock_out, .config_regs_out);
